/* File: hdl/mcg_params.svh */
// Register offsets, field positions, reset values and capability constants.
`ifndef MCG_PARAMS_SVH
`define MCG_PARAMS_SVH
`define MCG_OFF_CAPS_PINS   12'h01C_0
`define MCG_OFF_CAPS_PORTS  12'h01C
`define MCG_OFF_CAPS_PINS_A 12'h018
`define MCG_OFF_RUN_GATE    12'h100
`define MCG_OFF_SLEEP_GATE  12'h110
`define MCG_OFF_DEEP_GATE   12'h120
`define MCG_OFF_RUN_CFG     12'h060
`define MCG_OFF_MODE        12'h064
`define MCG_OFF_IRQ_STATUS  12'h070
`define MCG_OFF_IRQ_ENABLE  12'h074
`define MCG_OFF_IRQ_CLEAR   12'h078
`define MCG_BIT_WDT         3
`define MCG_BIT_ADC         16
`define MCG_RATE_LO         8
`define MCG_RATE_HI         9
`define MCG_BIT_AUTO_GATE   27
`define MCG_RUN_MASK        32'h0001_0308
`define MCG_DEEP_MASK       32'h0001_0008
`define MCG_GATE_RESET      32'h0000_0000
`define MCG_CAPS_PINS_VAL   32'h000F_0000
`define MCG_CAPS_PORTS_VAL  32'h0000_001F
`define MCG_RATE_LIMIT      2'h3
`endif

/* File: hdl/mcg_pkg.sv */
// Types shared by the module clock gating block.
package mcg_pkg;
    typedef enum logic [1:0] {
        MCG_MODE_RUN   = 2'b00,
        MCG_MODE_SLEEP = 2'b01,
        MCG_MODE_DEEP  = 2'b10
    } mcg_mode_t;

    typedef struct packed {
        logic        wdt_fault;
        logic        adc_fault;
    } mcg_events_t;

    typedef struct packed {
        logic [31:0] run_gate;
        logic [31:0] sleep_gate;
        logic [31:0] deep_gate;
        logic        auto_gate;
        logic [1:0]  irq_status;
        logic [1:0]  irq_enable;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        wdt_clk_en;
        logic        adc_clk_en;
        logic [1:0]  adc_rate;
        logic        wdt_fault;
        logic        adc_fault;
        logic [1:0]  mode_s1;
        logic [1:0]  mode_s2;
    } mcg_state_t;
endpackage : mcg_pkg

/* File: hdl/mcg_top.sv */
// APB clock gating controller with capability registers and unit fault checks.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "mcg_params.svh"

module mcg_top (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [1:0]           power_mode,
    input  wire logic                 wdt_access,
    input  wire logic                 adc_access,
    output logic                      wdt_clk_en,
    output logic                      adc_clk_en,
    output logic      [1:0]           adc_rate,
    output logic                      wdt_fault,
    output logic                      adc_fault,
    output logic                      irq
);
    import mcg_pkg::*;

    mcg_state_t  s_q;
    mcg_state_t  s_d;
    logic [31:0] gate_eff;
    logic [31:0] rdval;
    logic [1:0]  ev;
    logic [1:0]  wrate;
    logic        access;
    logic        hit;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d     = s_q;
        access  = psel && penable && !s_q.pready;
        hit     = 1'b1;
        rdval   = 32'h0000_0000;
        wrate   = pwdata[`MCG_RATE_HI:`MCG_RATE_LO];
        // Mode pins come from the power controller domain: two stages
        s_d.mode_s1 = power_mode;
        s_d.mode_s2 = s_q.mode_s1;
        // Without auto gating the run register holds in every mode
        gate_eff = s_q.run_gate;
        if (s_q.auto_gate) begin
            unique case (mcg_mode_t'(s_q.mode_s2))
                MCG_MODE_SLEEP: gate_eff = s_q.sleep_gate;
                MCG_MODE_DEEP:  gate_eff = s_q.deep_gate;
                default:        gate_eff = s_q.run_gate;
            endcase
        end
        s_d.wdt_clk_en = gate_eff[`MCG_BIT_WDT];
        s_d.adc_clk_en = gate_eff[`MCG_BIT_ADC];
        s_d.adc_rate   = gate_eff[`MCG_RATE_HI:`MCG_RATE_LO];
        // Unit accesses fault while their clock is off
        ev[1] = wdt_access && !s_q.wdt_clk_en;
        ev[0] = adc_access && !s_q.adc_clk_en;
        s_d.wdt_fault = ev[1];
        s_d.adc_fault = ev[0];
        // Address decode for reads
        unique case (paddr)
            `MCG_OFF_CAPS_PINS_A: rdval = `MCG_CAPS_PINS_VAL;
            `MCG_OFF_CAPS_PORTS:  rdval = `MCG_CAPS_PORTS_VAL;
            `MCG_OFF_RUN_GATE:    rdval = s_q.run_gate;
            `MCG_OFF_SLEEP_GATE:  rdval = s_q.sleep_gate;
            `MCG_OFF_DEEP_GATE:   rdval = s_q.deep_gate;
            `MCG_OFF_RUN_CFG:     rdval = {4'h0, s_q.auto_gate, 27'h000_0000};
            `MCG_OFF_MODE:        rdval = {30'h0000_0000, s_q.mode_s2};
            `MCG_OFF_IRQ_STATUS:  rdval = {30'h0000_0000, s_q.irq_status};
            `MCG_OFF_IRQ_ENABLE:  rdval = {30'h0000_0000, s_q.irq_enable};
            `MCG_OFF_IRQ_CLEAR:   rdval = 32'h0000_0000;
            default:              hit   = 1'b0;
        endcase
        // Rates above the cap fall back to the cap
        if (wrate > `MCG_RATE_LIMIT) begin
            wrate = `MCG_RATE_LIMIT;
        end
        // One wait state: answer lands on the second access cycle
        s_d.pready  = access;
        s_d.pslverr = access && !hit;
        s_d.prdata  = (access && !pwrite) ? rdval : 32'h0000_0000;
        if (access && pwrite && hit) begin
            unique case (paddr)
                `MCG_OFF_RUN_GATE: begin
                    s_d.run_gate = pwdata & `MCG_RUN_MASK;
                    s_d.run_gate[`MCG_RATE_HI:`MCG_RATE_LO] = wrate;
                end
                `MCG_OFF_SLEEP_GATE: begin
                    s_d.sleep_gate = pwdata & `MCG_RUN_MASK;
                    s_d.sleep_gate[`MCG_RATE_HI:`MCG_RATE_LO] = wrate;
                end
                `MCG_OFF_DEEP_GATE:  s_d.deep_gate = pwdata & `MCG_DEEP_MASK;
                `MCG_OFF_RUN_CFG:    s_d.auto_gate = pwdata[`MCG_BIT_AUTO_GATE];
                `MCG_OFF_IRQ_ENABLE: s_d.irq_enable = pwdata[1:0];
                `MCG_OFF_IRQ_CLEAR:  s_d.irq_status = s_q.irq_status & ~pwdata[1:0];
                default: ;
            endcase
        end
        // New fault events win over a clear in the same cycle
        s_d.irq_status = s_d.irq_status | ev;
        s_d.irq        = |(s_q.irq_status & s_q.irq_enable);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q            <= '0;
            s_q.run_gate   <= `MCG_GATE_RESET;
            s_q.sleep_gate <= `MCG_GATE_RESET;
            s_q.deep_gate  <= `MCG_GATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata     = s_q.prdata;
    assign pready     = s_q.pready;
    assign pslverr    = s_q.pslverr;
    assign wdt_clk_en = s_q.wdt_clk_en;
    assign adc_clk_en = s_q.adc_clk_en;
    assign adc_rate   = s_q.adc_rate;
    assign wdt_fault  = s_q.wdt_fault;
    assign adc_fault  = s_q.adc_fault;
    assign irq        = s_q.irq;
endmodule : mcg_top

/* File: verification/mcg_chk.sv */
// Port checker for the clock gating block
`timescale 1ns/1ps
module mcg_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        wdt_access,
    input wire logic        adc_access,
    input wire logic        wdt_clk_en,
    input wire logic        adc_clk_en,
    input wire logic        wdt_fault,
    input wire logic        adc_fault
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // Bus answers, caps and faults
    // ----
    sequence s_acc; psel && penable && !pready; endsequence
    sequence s_rd(a); psel && penable && !pready && !pwrite && paddr == a; endsequence
    chk_ready_next: assert property (s_acc |=> pready)
        else $error("pready not one cycle after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_idle_data: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    chk_unmapped_err: assert property (s_acc ##0 paddr == 12'h004 |=> pslverr && pready)
        else $error("no error on unmapped address");
    chk_pin_caps: assert property (s_rd(12'h018) |=> prdata == 32'h000F_0000)
        else $error("pin caps value wrong");
    chk_port_caps: assert property (s_rd(12'h01C) |=> prdata == 32'h0000_001F)
        else $error("port caps value wrong");
    chk_wdt_fault: assert property (wdt_access && !wdt_clk_en |=> wdt_fault)
        else $error("watchdog fault missing");
    chk_adc_fault: assert property (adc_access && !adc_clk_en |=> adc_fault)
        else $error("converter fault missing");
    chk_wdt_quiet: assert property (!(wdt_access && !wdt_clk_en) |=> !wdt_fault)
        else $error("spurious watchdog fault");
endmodule : mcg_chk

bind mcg_top mcg_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdt_access(wdt_access), .adc_access(adc_access), .wdt_clk_en(wdt_clk_en),
    .adc_clk_en(adc_clk_en), .wdt_fault(wdt_fault), .adc_fault(adc_fault));

/* File: verification/module_clock_gating_caps_tb_top.sv */
// Self-checking bench for the clock gating block
`timescale 1ns/1ps
module module_clock_gating_caps_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, wa, aa, er;
    logic        pready, pslverr, wen, aen, wf, af, irq;
    logic [1:0]  pm, rate;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          mismatches = 0;
    int          checks_done = 0;
    mcg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_mode(pm), .wdt_access(wa), .adc_access(aa), .wdt_clk_en(wen), .adc_clk_en(aen),
        .adc_rate(rate), .wdt_fault(wf), .adc_fault(af), .irq(irq));
    // 250 MHz clock
    always #2 pclk = ~pclk;
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        cmp(n, e, rd);
    endtask : rchk
    // Access pulse; the fault is a one-cycle pulse one edge later
    task automatic poke(input logic u, input logic e);
        if (u) wa <= 1'b1; else aa <= 1'b1;
        @(posedge pclk);
        {wa, aa} <= 2'b00;
        @(posedge pclk);
        cmp("fault", {31'h0, e}, {31'h0, u ? wf : af});
    endtask : poke
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    // Hang guard, far beyond the expected run
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        wrap_up();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, wa, aa, pm, paddr, pwdata} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk("run", 12'h100, 32'h0000_0000);
        rchk("sleep", 12'h110, 32'h0000_0000);
        rchk("deep", 12'h120, 32'h0000_0000);
        rchk("pins", 12'h018, 32'h000F_0000);
        apb(1'b1, 12'h01C, 32'h0000_0000);
        rchk("ports", 12'h01C, 32'h0000_001F);
        cmp("err", 32'h0, {31'h0, er});
        apb(1'b1, 12'h100, 32'hFFFF_FFFF);
        rchk("run", 12'h100, 32'h0001_0308);
        cmp("clk en", 32'h3, {30'h0, wen, aen});
        cmp("rate", 32'h3, {30'h0, rate});
        poke(1'b1, 1'b0);
        apb(1'b1, 12'h120, 32'hFFFF_FFFF);
        rchk("deep", 12'h120, 32'h0001_0008);
        // Faults set status; only enabled bits drive irq
        apb(1'b1, 12'h074, 32'h0000_0002);
        apb(1'b1, 12'h100, 32'h0000_0000);
        poke(1'b0, 1'b1);
        cmp("irq", 32'h0, {31'h0, irq});
        poke(1'b1, 1'b1);
        rchk("status", 12'h070, 32'h0000_0003);
        cmp("irq", 32'h1, {31'h0, irq});
        apb(1'b1, 12'h078, 32'h0000_0003);
        rchk("status", 12'h070, 32'h0000_0000);
        cmp("irq", 32'h0, {31'h0, irq});
        // Mode registers apply only with automatic gating set
        apb(1'b1, 12'h110, 32'h0000_0008);
        apb(1'b1, 12'h120, 32'h0000_0000);
        apb(1'b1, 12'h100, 32'h0001_0000);
        apb(1'b1, 12'h060, 32'h0800_0000);
        pm <= 2'b01;
        repeat (6) @(posedge pclk);
        cmp("sleep en", 32'h2, {30'h0, wen, aen});
        apb(1'b1, 12'h060, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        cmp("run en", 32'h1, {30'h0, wen, aen});
        apb(1'b1, 12'h060, 32'h0800_0000);
        pm <= 2'b10;
        repeat (6) @(posedge pclk);
        cmp("deep en", 32'h0, {30'h0, wen, aen});
        rchk("unmapped", 12'h004, 32'h0000_0000);
        cmp("err", 32'h1, {31'h0, er});
        wrap_up();
    end
endmodule : module_clock_gating_caps_tb_top
